// ---- hdl/rcss_div.sv ----
`timescale 1ns/10ps
`default_nettype none

module rcss_div
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // tick in and half period
    input wire logic i_tick,
    input wire logic [rcss_pkg::CNT_W-1:0] i_half,
    // divided clock
    output logic o_clk,
    output logic o_rise
);

    logic [rcss_pkg::CNT_W-1:0] cnt;
    logic [rcss_pkg::CNT_W-1:0] next_cnt;
    logic clk_q;
    logic next_clk;
    logic rise;
    logic next_rise;

    always_comb
    begin
        next_cnt = cnt;
        next_clk = clk_q;
        next_rise = 1'b0;
        if (i_tick)
        begin
            // >= guards a half period shrunk by a ratio change
            if (cnt + 6'h01 >= i_half)
            begin
                next_cnt = rcss_pkg::CNT_RESET;
                next_clk = ~clk_q;
                next_rise = ~clk_q;
            end
            else
            begin
                next_cnt = cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            cnt <= rcss_pkg::CNT_RESET;
            clk_q <= 1'b0;
            rise <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            clk_q <= next_clk;
            rise <= next_rise;
        end
    end

    assign o_clk = clk_q;
    assign o_rise = rise;

endmodule // rcss_div

`default_nettype wire

// ---- hdl/rcss_pkg.sv ----
package rcss_pkg;

    // ************************************************************
    // clock and widths
    // ************************************************************
    localparam int REF_CLK_PERIOD_NS = 100;
    localparam int CNT_W = 6;
    localparam int METER_W = 16;
    localparam int SYNC_W = 7;

    // ************************************************************
    // ratio codes: system clock multiple of the sampling rate
    // ************************************************************
    localparam logic [1:0] RATIO_128 = 2'h0;
    localparam logic [1:0] RATIO_256 = 2'h1;
    localparam logic [1:0] RATIO_384 = 2'h2;
    localparam logic [1:0] RATIO_512 = 2'h3;

    // pll source edges arrive at 3072 fs; half periods in source edges
    localparam logic [CNT_W-1:0] SYS_HALF_128 = 6'h0c;
    localparam logic [CNT_W-1:0] SYS_HALF_256 = 6'h06;
    localparam logic [CNT_W-1:0] SYS_HALF_384 = 6'h04;
    localparam logic [CNT_W-1:0] SYS_HALF_512 = 6'h03;

    // bit clock = system / 2, 4, 6, 8 -> half periods in system rises
    localparam logic [CNT_W-1:0] BIT_HALF_128 = 6'h01;
    localparam logic [CNT_W-1:0] BIT_HALF_256 = 6'h02;
    localparam logic [CNT_W-1:0] BIT_HALF_384 = 6'h03;
    localparam logic [CNT_W-1:0] BIT_HALF_512 = 6'h04;

    // reference source: system follows every reference edge, bit = sys / 4
    localparam logic [CNT_W-1:0] SYS_HALF_REF = 6'h01;
    localparam logic [CNT_W-1:0] BIT_HALF_REF = 6'h02;

    // frame = bit / 64
    localparam logic [CNT_W-1:0] FRAME_HALF = 6'h20;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [METER_W-1:0] METER_RESET = 16'h0000;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h00;

    typedef enum logic [0:0] {
        RCSS_SRC_PLL = 1'b0,
        RCSS_SRC_REF = 1'b1
    } rcss_src_t;

endpackage

// ---- hdl/rcss_top.sv ----
// Summary of operation
// - The system clock from the pll source is 128, 256, 384 or 512 fs for ratio codes 0 to 3.
// - From the pll source the bit clock is 64 fs and the frame clock 1 fs for every ratio code.
// - While locked the pll source is the clock recovered from the biphase stream.
// - While unlocked the pll source is the free-running vco clock.
// - The source-select input alone picks pll (low) or reference (high) for all three clocks.
// - With the select tied to the error flag, pll clocks go out on no error and reference on error.
// - With no reference clock present and the reference selected, no output clocks toggle.
// - Output clocks need not be continuous across a source change.
// - Decoding works at 28 to 108 kHz for every ratio code.
// - Clock recovery and decode never use the reference clock.
// - The reference clock times the measurement of the actual sampling rate.
// - With the reference selected no recovered data goes out and serial data is held low.
`timescale 1ns/10ps
`default_nettype none

module rcss_top
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // clock source pins
    input wire logic i_recovered_clk,
    input wire logic i_vco_free_clk,
    input wire logic i_pll_locked,
    input wire logic i_reference_clock_input,
    // control pins
    input wire logic i_clock_source_select,
    input wire logic [1:0] i_pll_clock_ratio_select,
    // decoder side, same clock
    input wire logic i_error_flag,
    input wire logic i_decoded_data,
    // clock outputs
    output logic o_system_clock_out,
    output logic o_bit_clock_out,
    output logic o_frame_clock_out,
    // data and measurement
    output logic o_serial_data,
    output logic [rcss_pkg::METER_W-1:0] o_rate_count
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [rcss_pkg::SYNC_W-1:0] pin_raw;
    logic [rcss_pkg::SYNC_W-1:0] sync1;
    logic [rcss_pkg::SYNC_W-1:0] sync2;
    logic [2:0] clk_prev;

    assign pin_raw = {i_pll_clock_ratio_select, i_clock_source_select, i_pll_locked,
                      i_reference_clock_input, i_vco_free_clk, i_recovered_clk};

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            sync1 <= rcss_pkg::SYNC_RESET;
            sync2 <= rcss_pkg::SYNC_RESET;
            clk_prev <= 3'h0;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            clk_prev <= sync2[2:0];
        end
    end

    logic rec_rise;
    logic vco_rise;
    logic ref_edge;
    logic ref_rise;
    logic locked;
    rcss_pkg::rcss_src_t src;
    logic [1:0] ratio;

    assign rec_rise = sync2[0] & ~clk_prev[0];
    assign vco_rise = sync2[1] & ~clk_prev[1];
    assign ref_rise = sync2[2] & ~clk_prev[2];
    // system clock follows the reference at its own rate, so both edges count
    assign ref_edge = sync2[2] ^ clk_prev[2];
    assign locked = sync2[3];
    assign src = rcss_pkg::rcss_src_t'(sync2[4]);
    assign ratio = sync2[6:5];

    // ************************************************************
    // source selection
    // ************************************************************
    logic pll_tick;
    logic sys_tick;
    logic [rcss_pkg::CNT_W-1:0] sys_half;
    logic [rcss_pkg::CNT_W-1:0] bit_half;

    // recovered clock while locked, vco free-run otherwise
    assign pll_tick = locked ? rec_rise : vco_rise;

    always_comb
    begin
        sys_half = rcss_pkg::SYS_HALF_REF;
        bit_half = rcss_pkg::BIT_HALF_REF;
        sys_tick = ref_edge;
        // select pin alone decides; in auto mode it carries the error flag
        unique case (src)
            rcss_pkg::RCSS_SRC_REF:
            begin
                // a still reference yields no edges, so outputs stop
                sys_tick = ref_edge;
            end
            rcss_pkg::RCSS_SRC_PLL:
            begin
                sys_tick = pll_tick;
                unique case (ratio)
                    rcss_pkg::RATIO_128:
                    begin
                        sys_half = rcss_pkg::SYS_HALF_128;
                        bit_half = rcss_pkg::BIT_HALF_128;
                    end
                    rcss_pkg::RATIO_256:
                    begin
                        sys_half = rcss_pkg::SYS_HALF_256;
                        bit_half = rcss_pkg::BIT_HALF_256;
                    end
                    rcss_pkg::RATIO_384:
                    begin
                        sys_half = rcss_pkg::SYS_HALF_384;
                        bit_half = rcss_pkg::BIT_HALF_384;
                    end
                    rcss_pkg::RATIO_512:
                    begin
                        sys_half = rcss_pkg::SYS_HALF_512;
                        bit_half = rcss_pkg::BIT_HALF_512;
                    end
                endcase
            end
        endcase
    end

    // ************************************************************
    // divider chain
    // ************************************************************
    // dividers keep counting across a source change; no glitch guard
    logic sys_rise;
    logic bit_rise;

    rcss_div u_sys_div
    (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_tick(sys_tick),
        .i_half(sys_half),
        .o_clk(o_system_clock_out),
        .o_rise(sys_rise)
    );

    // on the pll source every ratio gives 64 fs on the bit clock
    rcss_div u_bit_div
    (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_tick(sys_rise),
        .i_half(bit_half),
        .o_clk(o_bit_clock_out),
        .o_rise(bit_rise)
    );

    rcss_div u_frame_div
    (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_tick(bit_rise),
        .i_half(rcss_pkg::FRAME_HALF),
        .o_clk(o_frame_clock_out),
        .o_rise()
    );

    // ************************************************************
    // recovered-only frame and data path
    // ************************************************************
    // a pll-only frame divider that never sees the reference, so decode
    // timing stays independent of ratio and of the reference pin
    logic rsys_rise;
    logic rbit_rise;
    logic rframe_rise;

    rcss_div u_rsys_div
    (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_tick(pll_tick),
        .i_half(rcss_pkg::SYS_HALF_512),
        .o_clk(),
        .o_rise(rsys_rise)
    );

    rcss_div u_rbit_div
    (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_tick(rsys_rise),
        .i_half(rcss_pkg::BIT_HALF_512),
        .o_clk(),
        .o_rise(rbit_rise)
    );

    rcss_div u_rframe_div
    (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_tick(rbit_rise),
        .i_half(rcss_pkg::FRAME_HALF),
        .o_clk(),
        .o_rise(rframe_rise)
    );

    // ************************************************************
    // data mute and rate meter
    // ************************************************************
    logic serial_data;
    logic next_serial_data;
    logic [rcss_pkg::METER_W-1:0] meter;
    logic [rcss_pkg::METER_W-1:0] next_meter;
    logic [rcss_pkg::METER_W-1:0] rate;
    logic [rcss_pkg::METER_W-1:0] next_rate;

    always_comb
    begin
        // muted low on reference source or on error
        next_serial_data = i_decoded_data & ~i_error_flag & (src == rcss_pkg::RCSS_SRC_PLL);
        next_meter = meter;
        next_rate = rate;
        // reference rises counted per recovered frame
        if (rframe_rise)
        begin
            next_rate = meter;
            next_meter = {{(rcss_pkg::METER_W-1){1'b0}}, ref_rise};
        end
        else if (ref_rise && meter != {rcss_pkg::METER_W{1'b1}})
        begin
            next_meter = meter + 16'h0001;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_nrst)
        begin
            serial_data <= 1'b0;
            meter <= rcss_pkg::METER_RESET;
            rate <= rcss_pkg::METER_RESET;
        end
        else
        begin
            serial_data <= next_serial_data;
            meter <= next_meter;
            rate <= next_rate;
        end
    end

    assign o_serial_data = serial_data;
    assign o_rate_count = rate;

endmodule // rcss_top

`default_nettype wire

// ---- test/rcss_chk_sva.sv ----
`timescale 1ns/10ps
`default_nettype none

module rcss_chk
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // watched inputs
    input wire logic i_recovered_clk,
    input wire logic i_vco_free_clk,
    input wire logic i_reference_clock_input,
    input wire logic i_clock_source_select,
    input wire logic i_error_flag,
    input wire logic i_decoded_data,
    // watched outputs
    input wire logic o_system_clock_out,
    input wire logic o_bit_clock_out,
    input wire logic o_frame_clock_out,
    input wire logic o_serial_data,
    input wire logic [rcss_pkg::METER_W-1:0] o_rate_count
);
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);

    a_reset_all_low: assert property (disable iff (1'b0) !i_nrst |=> !o_system_clock_out && !o_bit_clock_out
        && !o_frame_clock_out && !o_serial_data && o_rate_count == 16'h0000) else $error("output high in reset");
    a_data_when_valid: assert property (o_serial_data |-> $past(i_decoded_data) && !$past(i_error_flag))
        else $error("data passed while muted");
    a_ref_mutes_data: assert property (i_clock_source_select [*4] |=> !o_serial_data)
        else $error("data passed on reference source");
    a_ref_absent_quiet: assert property ((i_clock_source_select && $stable(i_reference_clock_input)) [*8]
        |=> $stable(o_system_clock_out) && $stable(o_bit_clock_out)) else $error("clock without reference");
    a_pll_absent_quiet: assert property ((!i_clock_source_select && $stable(i_recovered_clk)
        && $stable(i_vco_free_clk)) [*8] |=> $stable(o_system_clock_out)) else $error("clock without pll source");
    a_ref_edge_follows: assert property (i_clock_source_select [*4] ##1 (i_clock_source_select
        && $changed(i_reference_clock_input)) ##1 i_clock_source_select [*3] |-> ##[0:3] $changed(o_system_clock_out))
        else $error("system clock missed a reference edge");
    // checked against the rise itself, so a torn system period at a source change cannot trip it
    a_bit_on_system: assert property ($changed(o_bit_clock_out)
        |-> $past(o_system_clock_out) && !$past(o_system_clock_out, 2))
        else $error("bit clock moved off a system rise");
    a_frame_on_bit: assert property ($changed(o_frame_clock_out)
        |-> $past(o_bit_clock_out) && !$past(o_bit_clock_out, 2))
        else $error("frame clock moved off a bit rise");
    a_pll_half_min: assert property ((!i_clock_source_select) [*6] ##1 $rose(o_system_clock_out)
        |-> o_system_clock_out [*8]) else $error("pll system half period too short");
endmodule // rcss_chk

bind rcss_top rcss_chk rcss_chk_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_recovered_clk(i_recovered_clk),
    .i_vco_free_clk(i_vco_free_clk), .i_reference_clock_input(i_reference_clock_input),
    .i_clock_source_select(i_clock_source_select), .i_error_flag(i_error_flag), .i_decoded_data(i_decoded_data),
    .o_system_clock_out(o_system_clock_out), .o_bit_clock_out(o_bit_clock_out),
    .o_frame_clock_out(o_frame_clock_out), .o_serial_data(o_serial_data), .o_rate_count(o_rate_count));

`default_nettype wire

// ---- test/rcss_sink.sv ----
`timescale 1ns/10ps
`default_nettype none

module rcss_sink
(
    // clock and window control
    input wire logic i_ref_clk,
    input wire logic i_clear,
    // consumed clocks
    input wire logic i_sys,
    input wire logic i_bit,
    input wire logic i_frame,
    // rises seen in the window
    output logic [15:0] o_sys_n,
    output logic [15:0] o_bit_n,
    output logic [15:0] o_frame_n
);
    logic [2:0] prev;

    // ************************************************************
    // rise counting
    // ************************************************************
    // counts rises only, so a torn period at a source change costs at most one
    always_ff @(posedge i_ref_clk)
    begin
        prev <= {i_sys, i_bit, i_frame};
        o_sys_n <= i_clear ? 16'h0000 : o_sys_n + 16'(i_sys & ~prev[2]);
        o_bit_n <= i_clear ? 16'h0000 : o_bit_n + 16'(i_bit & ~prev[1]);
        o_frame_n <= i_clear ? 16'h0000 : o_frame_n + 16'(i_frame & ~prev[0]);
    end
endmodule // rcss_sink

`default_nettype wire

// ---- test/recovered_clock_source_select_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module recovered_clock_source_select_tb;
    typedef struct packed {logic [7:0] ctl; logic [15:0] sys; logic [15:0] bitn; logic dout;} rcss_row_t;
    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic rst_req, sel = 1'b0, err = 1'b0, lock = 1'b0, src = 1'b0, rfon = 1'b0, clr = 1'b0;
    logic [1:0] ratio = 2'h0;
    logic din = 1'b1;
    logic sys, bitc, frm, dout;
    logic [15:0] rate, n_sys, n_bit, n_frm;
    int cyc = 0;
    int miscompares = 0;
    int samples_checked = 0;
    rcss_row_t rows [12];
    // recovered and reference pins held two cycles per level, vco pin four; a stopped source sits low
    wire logic rec_pin = src & cyc[1];
    wire logic vco_pin = src & cyc[2];
    wire logic ref_pin = rfon & cyc[1];

    rcss_top rcss_top_inst (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_recovered_clk(rec_pin),
        .i_vco_free_clk(vco_pin), .i_pll_locked(lock), .i_reference_clock_input(ref_pin),
        .i_clock_source_select(sel), .i_pll_clock_ratio_select(ratio), .i_error_flag(err), .i_decoded_data(din),
        .o_system_clock_out(sys), .o_bit_clock_out(bitc), .o_frame_clock_out(frm), .o_serial_data(dout),
        .o_rate_count(rate));
    rcss_sink rcss_sink_inst (.i_ref_clk(i_ref_clk), .i_clear(clr), .i_sys(sys), .i_bit(bitc), .i_frame(frm),
        .o_sys_n(n_sys), .o_bit_n(n_bit), .o_frame_n(n_frm));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic finish_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic measure(input int len);
        clr = 1'b1;
        @(posedge i_ref_clk);
        #1 clr = 1'b0;
        repeat (len) @(posedge i_ref_clk);
        #1;
    endtask

    initial
    begin
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk)
    begin
        cyc <= #1 cyc + 1;
        if (cyc == 90000)
        begin
            miscompares++;
            finish_test();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        // ctl = reset, ratio, select, error, locked, pll pins on, reference on
        rows[0] = {8'h86, 16'h0020, 16'h0010, 1'b1};
        rows[1] = {8'ha6, 16'h0040, 16'h0010, 1'b1};
        rows[2] = {8'hc6, 16'h0060, 16'h0010, 1'b1};
        rows[3] = {8'he6, 16'h0080, 16'h0010, 1'b1};
        rows[4] = {8'he2, 16'h0040, 16'h0008, 1'b1};
        rows[5] = {8'h82, 16'h0010, 16'h0008, 1'b1};
        rows[6] = {8'hd7, 16'h0300, 16'h00c0, 1'b0};
        rows[7] = {8'hd6, 16'h0000, 16'h0000, 1'b0};
        rows[8] = {8'he4, 16'h0000, 16'h0000, 1'b1};
        rows[9] = {8'hae, 16'h0040, 16'h0010, 1'b0};
        rows[10] = {8'hbf, 16'h0300, 16'h00c0, 1'b0};
        rows[11] = {8'h27, 16'h0040, 16'h0010, 1'b1};
        // first row adds four more reset cycles, sixteen in all
        repeat (12) @(posedge i_ref_clk);
        #1 check({12'h000, sys, bitc, frm, dout}, 16'h0000);
        check(rate, 16'h0000);
        foreach (rows[k])
        begin
            {rst_req, ratio, sel, err, lock, src, rfon} = rows[k].ctl;
            if (rst_req)
            begin
                i_nrst = 1'b0;
                repeat (4) @(posedge i_ref_clk);
                #1 i_nrst = 1'b1;
            end
            repeat (500) @(posedge i_ref_clk);
            #1 measure(3072);
            check(n_sys, rows[k].sys);
            check(n_bit, rows[k].bitn);
            check({15'h0000, dout}, {15'h0000, rows[k].dout});
        end
        // locked pll with reference running: one frame and one full meter update
        repeat (18000) @(posedge i_ref_clk);
        #1 measure(12288);
        check(n_frm, 16'h0001);
        check(rate, 16'h0c00);
        // data must follow the decoder input on the pll source, not a constant
        din = 1'b0;
        @(posedge i_ref_clk);
        #1 check({15'h0000, dout}, 16'h0000);
        din = 1'b1;
        @(posedge i_ref_clk);
        #1 check({15'h0000, dout}, 16'h0001);
        finish_test();
    end
endmodule // recovered_clock_source_select_tb

`default_nettype wire
